/* pkg/cmp_skip_pkg.sv */
// constants and opcode type for the compare, skip and branch unit
package cmp_skip_pkg;

  // ----------------------------------------------------------------
  // register byte addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_OPND_A  = 8'h00;
  localparam logic [7:0] ADDR_OPND_B  = 8'h04;
  localparam logic [7:0] ADDR_IO_VAL  = 8'h08;
  localparam logic [7:0] ADDR_PC      = 8'h0C;
  localparam logic [7:0] ADDR_FLAGS   = 8'h10;
  localparam logic [7:0] ADDR_EXEC    = 8'h14;
  localparam logic [7:0] ADDR_RESULT  = 8'h18;

  // ----------------------------------------------------------------
  // flag bit positions in flags_r
  // ----------------------------------------------------------------
  localparam int FLAG_C = 0;
  localparam int FLAG_Z = 1;
  localparam int FLAG_N = 2;
  localparam int FLAG_V = 3;

  // ----------------------------------------------------------------
  // execute word fields
  // ----------------------------------------------------------------
  localparam int OP_LSB       = 0;
  localparam int OP_W         = 4;
  localparam int SEL_LSB      = 4;
  localparam int SEL_W        = 3;
  localparam int TWO_WORD_BIT = 7;
  localparam int K_LSB        = 8;
  localparam int K_W          = 7;
  localparam int IMM_LSB      = 24;

  // ----------------------------------------------------------------
  // reset values and program counter steps
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_BYTE  = 8'h00;
  localparam int         STEP_SEQ  = 1;
  localparam int         SKIP_ONE  = 2;
  localparam int         SKIP_TWO  = 3;
  localparam int         BR_BIAS   = 1;

  typedef enum logic [3:0] {
    COMPARE_SKIP_EQUAL      = 4'h0,
    COMPARE_REGS            = 4'h1,
    COMPARE_REGS_WITH_CARRY = 4'h2,
    COMPARE_IMMEDIATE       = 4'h3,
    SKIP_REG_BIT_CLEAR      = 4'h4,
    SKIP_REG_BIT_SET        = 4'h5,
    SKIP_IO_BIT_CLEAR       = 4'h6,
    SKIP_IO_BIT_SET         = 4'h7,
    BRANCH_FLAG_SET         = 4'h8,
    BRANCH_FLAG_CLEAR       = 4'h9
  } exec_op_t;

endpackage

/* hw/cmp_skip_branch_exec.sv */
// compare, skip and branch execution unit with a wishbone register port
// Function
// - equal registers skip next instruction, flags kept
// - compare with carry sets Z N V C
// - immediate compare sets Z N V C only
// - register bit clear skips, flags kept
// - register bit set skips, flags kept
// - io bit clear skips, flags kept
// - io bit set skips, flags kept
// - set flag branches by k plus one
// - clear flag branches by k plus one
`timescale 1ns/1ps

module cmp_skip_branch_exec #(
  parameter int PC_W = 16
) (
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [7:0]        wb_adr_i,
  input  wire logic [3:0]        wb_sel_i,
  input  wire logic [31:0]       wb_dat_i,
  output logic      [31:0]       wb_dat_o,
  output logic                   wb_ack_o,
  output logic      [PC_W-1:0]   pc_o,
  output logic      [7:0]        flags_o,
  output logic                   taken_o
);

  // ----------------------------------------------------------------
  // parameter check
  // ----------------------------------------------------------------
  generate
    if (PC_W < 8 || PC_W > 32) begin : g_bad_pc_w
      $error("PC_W must lie between 8 and 32");
    end
  endgenerate

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [7:0]      opnd_a_r;
  logic [7:0]      opnd_a_nxt;
  logic [7:0]      opnd_b_r;
  logic [7:0]      opnd_b_nxt;
  logic [7:0]      io_val_r;
  logic [7:0]      io_val_nxt;
  logic [PC_W-1:0] pc_r;
  logic [PC_W-1:0] pc_nxt;
  logic [7:0]      flags_r;
  logic [7:0]      flags_nxt;
  logic [31:0]     exec_r;
  logic [31:0]     exec_nxt;
  logic            taken_r;
  logic            taken_nxt;
  logic            ack_r;
  logic            ack_nxt;
  logic [31:0]     rdata_r;
  logic [31:0]     rdata_nxt;

  // ----------------------------------------------------------------
  // bus decode and execute fields
  // ----------------------------------------------------------------
  localparam int SEL_W_C = cmp_skip_pkg::SEL_W;
  localparam int K_W_C   = cmp_skip_pkg::K_W;

  logic                   req;
  logic                   wr_fire;
  logic                   exec_fire;
  logic [7:0]             addr_w;
  cmp_skip_pkg::exec_op_t op;
  logic [SEL_W_C-1:0]     bsel;
  logic                   two_word;
  logic [7:0]             imm;
  logic [PC_W-1:0]        k_sext;

  assign req       = wb_cyc_i & wb_stb_i;
  // writes land only on the edge where the master sees ack
  assign wr_fire   = req & wb_we_i & ack_r;
  assign addr_w    = {wb_adr_i[7:2], 2'b00};
  assign exec_fire = wr_fire & (addr_w == cmp_skip_pkg::ADDR_EXEC)
                     & wb_sel_i[0] & wb_sel_i[1];

  assign op       = cmp_skip_pkg::exec_op_t'(
                      wb_dat_i[cmp_skip_pkg::OP_LSB +: cmp_skip_pkg::OP_W]);
  assign bsel     = wb_dat_i[cmp_skip_pkg::SEL_LSB +: SEL_W_C];
  assign two_word = wb_dat_i[cmp_skip_pkg::TWO_WORD_BIT];
  assign imm      = wb_dat_i[cmp_skip_pkg::IMM_LSB +: 8];
  assign k_sext   = {{(PC_W-K_W_C){wb_dat_i[cmp_skip_pkg::K_LSB+K_W_C-1]}},
                     wb_dat_i[cmp_skip_pkg::K_LSB +: K_W_C]};

  // ----------------------------------------------------------------
  // subtract and flag logic
  // ----------------------------------------------------------------
  logic [7:0] sub_b;
  logic       cin;
  logic [8:0] diff;
  logic [7:0] res;
  logic       v_new;
  logic       z_new;

  always_comb begin
    sub_b = (op == cmp_skip_pkg::COMPARE_IMMEDIATE) ?
            imm : opnd_b_r;
    cin   = (op == cmp_skip_pkg::COMPARE_REGS_WITH_CARRY) ?
            flags_r[cmp_skip_pkg::FLAG_C] : 1'b0;
    diff  = {1'b0, opnd_a_r} - {1'b0, sub_b} - {8'h00, cin};
    res   = diff[7:0];
    v_new = (opnd_a_r[7] & ~sub_b[7] & ~res[7]) |
            (~opnd_a_r[7] & sub_b[7] & res[7]);
    // with carry, zero can only be kept or cleared, so multi-byte compares chain
    z_new = (res == 8'h00) &
            ((op != cmp_skip_pkg::COMPARE_REGS_WITH_CARRY) |
             flags_r[cmp_skip_pkg::FLAG_Z]);
  end

  // ----------------------------------------------------------------
  // program counter candidates
  // ----------------------------------------------------------------
  logic [PC_W-1:0] pc_seq;
  logic [PC_W-1:0] pc_skip;
  logic [PC_W-1:0] pc_br;
  logic            cond;

  always_comb begin
    pc_seq  = pc_r + PC_W'(cmp_skip_pkg::STEP_SEQ);
    pc_skip = pc_r + (two_word ? PC_W'(cmp_skip_pkg::SKIP_TWO)
                               : PC_W'(cmp_skip_pkg::SKIP_ONE));
    pc_br   = pc_r + k_sext + PC_W'(cmp_skip_pkg::BR_BIAS);
    case (op)
      cmp_skip_pkg::COMPARE_SKIP_EQUAL:
        cond = (opnd_a_r == opnd_b_r);
      cmp_skip_pkg::SKIP_REG_BIT_CLEAR: cond = ~opnd_b_r[bsel];
      cmp_skip_pkg::SKIP_REG_BIT_SET:   cond = opnd_b_r[bsel];
      cmp_skip_pkg::SKIP_IO_BIT_CLEAR:  cond = ~io_val_r[bsel];
      cmp_skip_pkg::SKIP_IO_BIT_SET:    cond = io_val_r[bsel];
      cmp_skip_pkg::BRANCH_FLAG_SET:    cond = flags_r[bsel];
      cmp_skip_pkg::BRANCH_FLAG_CLEAR:  cond = ~flags_r[bsel];
      default:               cond = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    opnd_a_nxt = opnd_a_r;
    opnd_b_nxt = opnd_b_r;
    io_val_nxt = io_val_r;
    pc_nxt     = pc_r;
    flags_nxt  = flags_r;
    exec_nxt   = exec_r;
    taken_nxt  = taken_r;
    ack_nxt    = req & ~ack_r;
    rdata_nxt  = 32'h0000_0000;
    case (addr_w)
      cmp_skip_pkg::ADDR_OPND_A: rdata_nxt[7:0] = opnd_a_r;
      cmp_skip_pkg::ADDR_OPND_B: rdata_nxt[7:0] = opnd_b_r;
      cmp_skip_pkg::ADDR_IO_VAL: rdata_nxt[7:0] = io_val_r;
      cmp_skip_pkg::ADDR_PC:     rdata_nxt[PC_W-1:0] = pc_r;
      cmp_skip_pkg::ADDR_FLAGS:  rdata_nxt[7:0] = flags_r;
      cmp_skip_pkg::ADDR_EXEC:   rdata_nxt = exec_r;
      cmp_skip_pkg::ADDR_RESULT: rdata_nxt[0] = taken_r;
      default:                   rdata_nxt = 32'h0000_0000;
    endcase
    if (wr_fire) begin
      case (addr_w)
        cmp_skip_pkg::ADDR_OPND_A: begin
          if (wb_sel_i[0]) opnd_a_nxt = wb_dat_i[7:0];
        end
        cmp_skip_pkg::ADDR_OPND_B: begin
          if (wb_sel_i[0]) opnd_b_nxt = wb_dat_i[7:0];
        end
        cmp_skip_pkg::ADDR_IO_VAL: begin
          if (wb_sel_i[0]) io_val_nxt = wb_dat_i[7:0];
        end
        cmp_skip_pkg::ADDR_PC: begin
          if (wb_sel_i[0] & wb_sel_i[1]) pc_nxt = wb_dat_i[PC_W-1:0];
        end
        cmp_skip_pkg::ADDR_FLAGS: begin
          if (wb_sel_i[0]) flags_nxt = wb_dat_i[7:0];
        end
        default: begin
        end
      endcase
    end
    if (exec_fire) begin
      exec_nxt  = wb_dat_i;
      taken_nxt = cond;
      case (op)
        cmp_skip_pkg::COMPARE_REGS,
        cmp_skip_pkg::COMPARE_REGS_WITH_CARRY,
        cmp_skip_pkg::COMPARE_IMMEDIATE: begin
          flags_nxt[cmp_skip_pkg::FLAG_C] = diff[8];
          flags_nxt[cmp_skip_pkg::FLAG_Z] = z_new;
          flags_nxt[cmp_skip_pkg::FLAG_N] = res[7];
          flags_nxt[cmp_skip_pkg::FLAG_V] = v_new;
          pc_nxt = pc_seq;
        end
        cmp_skip_pkg::COMPARE_SKIP_EQUAL,
        cmp_skip_pkg::SKIP_REG_BIT_CLEAR,
        cmp_skip_pkg::SKIP_REG_BIT_SET,
        cmp_skip_pkg::SKIP_IO_BIT_CLEAR,
        cmp_skip_pkg::SKIP_IO_BIT_SET:
          pc_nxt = cond ? pc_skip : pc_seq;
        cmp_skip_pkg::BRANCH_FLAG_SET,
        cmp_skip_pkg::BRANCH_FLAG_CLEAR:
          pc_nxt = cond ? pc_br : pc_seq;
        default: taken_nxt = 1'b0;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      opnd_a_r <= cmp_skip_pkg::RST_BYTE;
      opnd_b_r <= cmp_skip_pkg::RST_BYTE;
      io_val_r <= cmp_skip_pkg::RST_BYTE;
      pc_r     <= '0;
      flags_r  <= cmp_skip_pkg::RST_BYTE;
      exec_r   <= 32'h0000_0000;
      taken_r  <= 1'b0;
      ack_r    <= 1'b0;
      rdata_r  <= 32'h0000_0000;
    end else begin
      opnd_a_r <= opnd_a_nxt;
      opnd_b_r <= opnd_b_nxt;
      io_val_r <= io_val_nxt;
      pc_r     <= pc_nxt;
      flags_r  <= flags_nxt;
      exec_r   <= exec_nxt;
      taken_r  <= taken_nxt;
      ack_r    <= ack_nxt;
      rdata_r  <= rdata_nxt;
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = rdata_r;
  assign pc_o     = pc_r;
  assign flags_o  = flags_r;
  assign taken_o  = taken_r;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_equal_skip: assert property (
    exec_fire && op == cmp_skip_pkg::COMPARE_SKIP_EQUAL
    && opnd_a_r == opnd_b_r
    |=> pc_r - $past(pc_r) == ($past(two_word) ? PC_W'(3) : PC_W'(2))
        && flags_r == $past(flags_r))
    else $error("equal compare did not skip");

  a_carry_cmp_flags: assert property (
    exec_fire && op == cmp_skip_pkg::COMPARE_REGS_WITH_CARRY
    |=> flags_r[cmp_skip_pkg::FLAG_C] ==
        ({1'b0, $past(opnd_a_r)} <
         {1'b0, $past(opnd_b_r)} + {8'h00, $past(cin)})
        && opnd_a_r == $past(opnd_a_r))
    else $error("carry compare borrow wrong");

  a_imm_cmp_zero: assert property (
    exec_fire && op == cmp_skip_pkg::COMPARE_IMMEDIATE
    |=> flags_r[cmp_skip_pkg::FLAG_Z] == ($past(opnd_a_r) == $past(imm))
        && opnd_a_r == $past(opnd_a_r) && pc_r == $past(pc_r) + PC_W'(1))
    else $error("immediate compare wrong");

  a_rbit_clear_skip: assert property (
    exec_fire && op == cmp_skip_pkg::SKIP_REG_BIT_CLEAR && !opnd_b_r[bsel]
    |=> pc_r == $past(pc_r) + ($past(two_word)
                               ? PC_W'(cmp_skip_pkg::SKIP_TWO)
                               : PC_W'(cmp_skip_pkg::SKIP_ONE))
        && flags_r == $past(flags_r))
    else $error("register bit clear skip wrong");

  a_rbit_set_skip: assert property (
    exec_fire && op == cmp_skip_pkg::SKIP_REG_BIT_SET
    |=> taken_r == $past(opnd_b_r[bsel]) && flags_r == $past(flags_r))
    else $error("register bit set skip wrong");

  a_iobit_clear_skip: assert property (
    exec_fire && op == cmp_skip_pkg::SKIP_IO_BIT_CLEAR && io_val_r[bsel]
    |=> pc_r == $past(pc_r) + PC_W'(1) && !taken_r)
    else $error("io bit clear skip wrong");

  a_iobit_set_skip: assert property (
    exec_fire && op == cmp_skip_pkg::SKIP_IO_BIT_SET && io_val_r[bsel]
    |=> taken_r && flags_r == $past(flags_r))
    else $error("io bit set skip wrong");

  a_flag_set_jump: assert property (
    exec_fire && op == cmp_skip_pkg::BRANCH_FLAG_SET && flags_r[bsel]
    |=> pc_r == $past(pc_r) + $past(k_sext) + PC_W'(1)
        && flags_r == $past(flags_r))
    else $error("branch on set wrong");

  a_flag_clear_jump: assert property (
    exec_fire && op == cmp_skip_pkg::BRANCH_FLAG_CLEAR && flags_r[bsel]
    |=> pc_r == $past(pc_r) + PC_W'(1))
    else $error("branch on clear taken wrongly");

  a_flag_clear_taken: assert property (
    exec_fire && op == cmp_skip_pkg::BRANCH_FLAG_CLEAR && !flags_r[bsel]
    |=> pc_r == $past(pc_r) + $past(k_sext) + PC_W'(1)
        && flags_r == $past(flags_r))
    else $error("branch on clear not taken");

  a_plain_cmp_flags: assert property (
    exec_fire && op == cmp_skip_pkg::COMPARE_REGS
    |=> flags_r[cmp_skip_pkg::FLAG_C] == ($past(opnd_a_r) < $past(opnd_b_r))
        && flags_r[cmp_skip_pkg::FLAG_Z] ==
           ($past(opnd_a_r) == $past(opnd_b_r)))
    else $error("plain compare flags wrong");

  a_ack_once: assert property (
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held two cycles");

endmodule // cmp_skip_branch_exec

/* verif/tb.sv */
// self-checking bench for the compare, skip and branch execution unit
`timescale 1ns/1ps

module tb;
  // ----------------------------------------------------------------
  // clock, reset and design instance
  // ----------------------------------------------------------------
  localparam int PC_W = 16;

  logic              clk_i;
  logic              rst_i;
  logic              wb_cyc_i;
  logic              wb_stb_i;
  logic              wb_we_i;
  logic [7:0]        wb_adr_i;
  logic [3:0]        wb_sel_i;
  logic [31:0]       wb_dat_i;
  logic [31:0]       wb_dat_o;
  logic              wb_ack_o;
  logic [PC_W-1:0]   pc_o;
  logic [7:0]        flags_o;
  logic              taken_o;
  logic [31:0]       exp_q[$];
  logic [PC_W+8:0]   out_q[$];
  logic              exec_seen = 1'b0;
  int                fail_count;
  int                cmp_count;
  int                cyc_cnt;

  cmp_skip_branch_exec #(.PC_W(PC_W)) u_cmp_skip_branch_exec (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .wb_cyc_i (wb_cyc_i),
    .wb_stb_i (wb_stb_i),
    .wb_we_i  (wb_we_i),
    .wb_adr_i (wb_adr_i),
    .wb_sel_i (wb_sel_i),
    .wb_dat_i (wb_dat_i),
    .wb_dat_o (wb_dat_o),
    .wb_ack_o (wb_ack_o),
    .pc_o     (pc_o),
    .flags_o  (flags_o),
    .taken_o  (taken_o)
  );

  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end

  // ----------------------------------------------------------------
  // closing report and hang guard
  // ----------------------------------------------------------------
  task automatic tally_and_finish();
    if (fail_count == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  always @(posedge clk_i) begin
    cyc_cnt++;
    if (cyc_cnt > 20000) begin
      fail_count++;
      tally_and_finish();
    end
  end

  // ----------------------------------------------------------------
  // bus master tasks
  // ----------------------------------------------------------------
  // no local limit: only the bench timeout ends a stuck wait
  task automatic wb_xfer(input logic we, input logic [7:0] adr,
                         input logic [31:0] d);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= adr;
    wb_sel_i <= 4'hF;
    wb_dat_i <= d;
    do begin
      @(posedge clk_i);
    end while (wb_ack_o !== 1'b1);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask

  // a read notes its expected data, the monitor checks it at ack
  task automatic rd(input logic [7:0] adr, input logic [31:0] e);
    exp_q.push_back(e);
    wb_xfer(1'b0, adr, 32'h0000_0000);
  endtask

  task automatic cmp_rd(input logic [31:0] got, input logic [31:0] e);
    cmp_count++;
    if (got !== e) begin
      fail_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, e);
    end
  endtask

  task automatic cmp_out(input logic [PC_W+8:0] got,
                         input logic [PC_W+8:0] e);
    cmp_count++;
    if (got !== e) begin
      fail_count++;
      $display("ERROR t=%0t out got=%h exp=%h", $time, got, e);
    end
  endtask

  always @(posedge clk_i) begin
    if (wb_ack_o === 1'b1 && wb_we_i === 1'b0) begin
      if (exp_q.size() == 0) cmp_rd(wb_dat_o, ~wb_dat_o);
      else cmp_rd(wb_dat_o, exp_q.pop_front());
    end
  end

  // pc, flags and taken are checked the cycle after an execute lands
  always @(posedge clk_i) begin
    if (exec_seen) begin
      if (out_q.size() == 0)
        cmp_out({pc_o, flags_o, taken_o}, ~{pc_o, flags_o, taken_o});
      else
        cmp_out({pc_o, flags_o, taken_o}, out_q.pop_front());
    end
    exec_seen <= (wb_ack_o === 1'b1 && wb_we_i === 1'b1 &&
                  wb_adr_i === cmp_skip_pkg::ADDR_EXEC);
  end

  // ----------------------------------------------------------------
  // one executed instruction against the reference reckoning
  // ----------------------------------------------------------------
  task automatic run_case(input logic [3:0] op);
    logic [7:0]  a, b, io, fl, rhs, r, fe;
    logic [15:0] pc, pe;
    logic [31:0] w;
    logic        cin, cond;
    a  = 8'($urandom);
    b  = ($urandom % 2) ? a : 8'($urandom);
    io = 8'($urandom);
    fl = 8'($urandom);
    pc = 16'($urandom);
    w  = {8'($urandom), 9'h000, 7'($urandom), 4'($urandom), op};
    if (op == 4'h3 && b[0]) w[31:24] = a;
    cin  = (op == 4'h2) ? fl[0] : 1'b0;
    rhs  = (op == 4'h3) ? w[31:24] : b;
    r    = a - rhs - {7'h00, cin};
    fe   = fl;
    pe   = pc + 16'h0001;
    cond = 1'b0;
    case (op)
      4'h1, 4'h2, 4'h3: begin
        fe[0] = ({1'b0, a} < {1'b0, rhs} + {8'h00, cin});
        fe[1] = (r == 8'h00) && (op != 4'h2 || fl[1]);
        fe[2] = r[7];
        fe[3] = (a[7] & ~rhs[7] & ~r[7]) | (~a[7] & rhs[7] & r[7]);
      end
      4'h0: cond = (a == b);
      4'h4: cond = ~b[w[6:4]];
      4'h5: cond = b[w[6:4]];
      4'h6: cond = ~io[w[6:4]];
      4'h7: cond = io[w[6:4]];
      4'h8: cond = fl[w[6:4]];
      4'h9: cond = ~fl[w[6:4]];
      default: pe = pc;
    endcase
    if (cond && op < 4'h8) pe = pc + (w[7] ? 16'h0003 : 16'h0002);
    if (cond && op >= 4'h8) pe = pc + {{9{w[14]}}, w[14:8]} + 16'h0001;
    wb_xfer(1'b1, cmp_skip_pkg::ADDR_OPND_A, {24'h000000, a});
    wb_xfer(1'b1, cmp_skip_pkg::ADDR_OPND_B, {24'h000000, b});
    wb_xfer(1'b1, cmp_skip_pkg::ADDR_IO_VAL, {24'h000000, io});
    wb_xfer(1'b1, cmp_skip_pkg::ADDR_PC, {16'h0000, pc});
    wb_xfer(1'b1, cmp_skip_pkg::ADDR_FLAGS, {24'h000000, fl});
    out_q.push_back({pe, fe, cond});
    wb_xfer(1'b1, cmp_skip_pkg::ADDR_EXEC, w);
    rd(cmp_skip_pkg::ADDR_PC, {16'h0000, pe});
    rd(cmp_skip_pkg::ADDR_FLAGS, {24'h000000, fe});
    rd(cmp_skip_pkg::ADDR_EXEC, w);
    rd(cmp_skip_pkg::ADDR_RESULT, {31'h00000000, cond});
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    rst_i      = 1'b1;
    wb_cyc_i   = 1'b0;
    wb_stb_i   = 1'b0;
    wb_we_i    = 1'b0;
    wb_adr_i   = 8'h00;
    wb_sel_i   = 4'hF;
    wb_dat_i   = 32'h0000_0000;
    fail_count = 0;
    cmp_count  = 0;
    cyc_cnt    = 0;
    void'($urandom(27086));
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(cmp_skip_pkg::ADDR_PC, 32'h0000_0000);
    rd(cmp_skip_pkg::ADDR_FLAGS, 32'h0000_0000);
    rd(cmp_skip_pkg::ADDR_OPND_A, 32'h0000_0000);
    // read-only result and an unmapped address both ignore writes
    wb_xfer(1'b1, cmp_skip_pkg::ADDR_RESULT, 32'hFFFF_FFFF);
    rd(cmp_skip_pkg::ADDR_RESULT, 32'h0000_0000);
    wb_xfer(1'b1, 8'hFC, 32'hFFFF_FFFF);
    rd(8'hFC, 32'h0000_0000);
    for (int o = 0; o < 12; o++) begin
      repeat (12) run_case(4'(o));
    end
    repeat (4) @(posedge clk_i);
    if (exp_q.size() != 0 || out_q.size() != 0) fail_count++;
    tally_and_finish();
  end
endmodule // tb
